// file: inc/pcc_pkg.sv
// Shared constants for the clock controller: register map, field layout,
// reset values and counts.
package pcc_pkg;

    // Address of the clock control register in the I/O space.
    localparam logic [15:0] CTRL_ADDR = 16'h0200;
    // Control register width.
    localparam int CTRL_W = 16;
    // Reset value of the control register before the straps are taken.
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // Bit positions inside the control register.
    localparam int BIT_HALVE = 0;
    localparam int BIT_SHUTOFF = 1;
    localparam int BIT_HALT_ALL = 2;
    localparam int BIT_HALT_CORE = 3;
    localparam int BIT_RATIO = 4;
    localparam int BIT_SLEEP = 5;
    localparam int BIT_CKOUT = 6;
    localparam int BIT_BYP_HALF = 7;
    localparam int BIT_BYPASS = 8;
    localparam int MSEL_LSB = 9;
    localparam int MSEL_W = 7;
    // Positions inside the multiplier field.
    localparam int MSEL_B5 = 5;
    localparam int MSEL_B6 = 6;
    localparam int FACTOR_W = 5;

    // Factor used for multiplier code zero, and the quarter-step scaling.
    localparam logic [5:0] FULL_FACTOR = 6'h20;
    localparam logic [1:0] QUARTER_PAD = 2'h0;

    // Lock interval in input clock cycles (500).
    localparam int LOCK_W = 9;
    localparam logic [8:0] LOCK_CYCLES = 9'h1F4;

    // Strap bundle layout: multiplier, bypass, input halving.
    localparam int STRAP_W = 9;
    localparam int STRAP_HALVE = 0;
    localparam int STRAP_BYPASS = 1;
    localparam int STRAP_MSEL_LSB = 2;
    // Cycles after reset release before the synchronised straps are valid.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

// file: hdl/pcc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for pins that arrive from outside the clock domain.
module pcc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // First stage; only the second stage ever reads it.
    logic [W-1:0] meta;

    // Both stages reset to zero so the output is defined from reset onward.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule
`default_nettype wire

// file: hdl/pcc_clk_switch.sv
`timescale 1ns/1ps
`default_nettype none

// Registered clock selector with a hold-high gate.  Sources are square
// waves built on the system clock.  A source change is made only while both
// sources and the output are high, and the gate engages or releases only
// while the output and the chosen source are high, so no runt pulse forms.
module pcc_clk_switch (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic src_a_i,
    input wire logic src_b_i,
    input wire logic sel_b_i,
    input wire logic halt_i,
    output logic clk_o
);

    logic cur_sel; // Source actually in use.
    logic held; // Output parked high.
    logic next_sel;
    logic next_held;
    logic cur_src;

    // Decide the next source and gate state at safe instants only.
    always_comb
    begin
        next_sel = cur_sel;
        next_held = held;
        // Waiting for a common high phase costs latency but never a glitch.
        if ((sel_b_i != cur_sel) && src_a_i && src_b_i && clk_o)
        begin
            next_sel = sel_b_i;
        end
        cur_src = next_sel ? src_b_i : src_a_i;
        if (halt_i && clk_o && cur_src)
        begin
            next_held = 1'b1;
        end
        else if (!halt_i && cur_src)
        begin
            next_held = 1'b0;
        end
    end

    // State and the output clock come straight from flip-flops.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cur_sel <= 1'b0;
            held <= 1'b0;
            clk_o <= 1'b0;
        end
        else
        begin
            cur_sel <= next_sel;
            held <= next_held;
            clk_o <= next_held | cur_src;
        end
    end

endmodule
`default_nettype wire

// file: hdl/pcc_pll_clock_controller.sv
// Summary of operation
// - Bit 0 halves input clock before loop, unless multiplier bit 5 is set.
// - Bit 1 set turns the loop off.
// - Bit 2 holds core and peripheral clocks high.
// - Bit 3 holds core clock high.
// - Bit 4 makes peripheral clock half core.
// - Bit 5 puts loop into low power.
// - Bit 6 lets clock pin follow peripheral clock.
// - Bit 7 halves core clock in bypass.
// - Bit 8 selects bypass or multiplier operation.
// - Bits 15..9 multiplier, loaded from straps.
// - Straps set multiplier, bypass, halving at reset.
// - Start in bypass, core from input clock.
// - Low five bits give factor, zero means 32.
// - Input halving halves both; bit 6 core only.
// - Stay in bypass until lock count expires.
// - Lock interval is 500 input clock cycles.
`timescale 1ns/1ps
`default_nettype none

// The loop is modelled digitally: the input clock arrives on a pin, is
// synchronised, and the loop output is a phase accumulator on the system
// clock whose step is the chosen ratio scaled by the nominal number of system
// cycles per input cycle.  The system clock must be well above the fastest
// derived clock for this model to hold.
module pcc_pll_clock_controller #(
    parameter int ACC_W = 16, // Phase accumulator width.
    parameter int REF_LOG2 = 6, // Log2 of system cycles per input period.
    parameter int ADDR_W = 16 // I/O address width.
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic input_clk_i,
    input wire logic [6:0] multiplier_strap_i,
    input wire logic bypass_strap_i,
    input wire logic input_halving_strap_i,
    input wire logic [ADDR_W-1:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    output logic [8:0] lock_counter_reg_o,
    output logic pll_locked_o,
    output logic core_clk_o,
    output logic periph_clk_o,
    output logic clock_out_pin_o,
    output logic pll_vco_clk_o
);

    // Shift that turns a ratio in quarter steps into an accumulator step.
    localparam int INC_SHIFT = ACC_W - 2 - REF_LOG2;

    // Ratio in quarter steps of the input clock, with the two halvings.
    function automatic logic [7:0] ratio_quarters(
        input logic [4:0] code,
        input logic halve_a,
        input logic halve_b
    );
        logic [7:0] q;
        q = (code == 5'h00) ? {pcc_pkg::FULL_FACTOR, pcc_pkg::QUARTER_PAD}
                            : {1'b0, code, pcc_pkg::QUARTER_PAD};
        if (halve_a)
        begin
            q = q >> 1;
        end
        if (halve_b)
        begin
            q = q >> 1;
        end
        return q;
    endfunction

    logic [15:0] ctrl; // Clock control register.
    logic ref_s; // Synchronised input clock.
    logic ref_d; // Previous synchronised input clock.
    logic ref_rise; // One-cycle pulse on an input clock rising edge.
    logic [pcc_pkg::STRAP_W-1:0] strap_s; // Synchronised straps.
    logic [1:0] settle_cnt; // Wait for straps to pass the synchroniser.
    logic strap_done; // Straps have been taken.
    logic strap_load; // One-cycle strap capture.
    logic addr_hit; // Address matches the control register.
    logic wr_hit; // Accepted register write.
    logic [6:0] msel; // Multiplier field.
    logic halve_in; // Effective input halving.
    logic loop_on; // Loop powered and running.
    logic [7:0] cfg_prev; // Last ratio setting seen by the lock counter.
    logic [8:0] lock_cnt; // Lock interval counter.
    logic locked; // Lock interval complete.
    logic use_loop; // Core fed from the loop output.
    logic [ACC_W-1:0] vco_acc; // Loop oscillator phase.
    logic [ACC_W-1:0] core_acc; // Core clock phase from the loop.
    logic [ACC_W-1:0] vco_inc;
    logic [ACC_W-1:0] core_inc;
    logic byp_half; // Input clock divided by two.
    logic bypass_src; // Bypass path clock.
    logic core_raw; // Selected core source before gating.
    logic core_raw_d; // Previous core source level.
    logic core_half; // Core source divided by two.

    // Input clock pin passes two flops before anything reads it.
    pcc_sync #(
        .W(1)
    ) u_ref_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(input_clk_i),
        .q_o(ref_s)
    );

    // Straps are synchronised too; their value is used only once settled.
    pcc_sync #(
        .W(pcc_pkg::STRAP_W)
    ) u_strap_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({multiplier_strap_i, bypass_strap_i, input_halving_strap_i}),
        .q_o(strap_s)
    );

    // Edge detector reads only the second synchroniser stage.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ref_d <= 1'b0;
        end
        else
        begin
            ref_d <= ref_s;
        end
    end

    assign ref_rise = ref_s & ~ref_d;

    // Strap capture happens a few cycles after release, never under reset,
    // because an asynchronous reset may only load constants.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            settle_cnt <= 2'h0;
            strap_done <= 1'b0;
        end
        else if (!strap_done)
        begin
            if (settle_cnt == pcc_pkg::STRAP_SETTLE)
            begin
                strap_done <= 1'b1;
            end
            else
            begin
                settle_cnt <= settle_cnt + 2'h1;
            end
        end
    end

    assign strap_load = !strap_done && (settle_cnt == pcc_pkg::STRAP_SETTLE);
    assign addr_hit = (io_addr_i == ADDR_W'(pcc_pkg::CTRL_ADDR));
    // Writes before the straps are taken are dropped so they cannot race it.
    assign wr_hit = io_wr_i && strap_done && addr_hit;

    // Control register: straps first, then software writes.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl <= pcc_pkg::CTRL_RST;
        end
        else if (strap_load)
        begin
            ctrl[pcc_pkg::MSEL_LSB +: pcc_pkg::MSEL_W] <=
                strap_s[pcc_pkg::STRAP_MSEL_LSB +: pcc_pkg::MSEL_W];
            ctrl[pcc_pkg::BIT_BYPASS] <= strap_s[pcc_pkg::STRAP_BYPASS];
            ctrl[pcc_pkg::BIT_HALVE] <= strap_s[pcc_pkg::STRAP_HALVE];
        end
        else if (wr_hit)
        begin
            ctrl <= io_wdata_i;
        end
    end

    // Read data is registered; a miss returns zero.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            io_rdata_o <= 16'h0000;
        end
        else if (io_rd_i && addr_hit)
        begin
            io_rdata_o <= ctrl;
        end
        else
        begin
            io_rdata_o <= 16'h0000;
        end
    end

    // Field decode.  With multiplier bit 5 set the caller also sets input
    // halving, and the ratios then match bit 5 clear with no halving.
    assign msel = ctrl[pcc_pkg::MSEL_LSB +: pcc_pkg::MSEL_W];
    assign halve_in = ctrl[pcc_pkg::BIT_HALVE] & ~msel[pcc_pkg::MSEL_B5];
    assign loop_on = ~ctrl[pcc_pkg::BIT_SHUTOFF] & ~ctrl[pcc_pkg::BIT_SLEEP];

    // Step sizes of the loop oscillator and of the core clock taken from it.
    assign vco_inc = ACC_W'(ratio_quarters(msel[pcc_pkg::FACTOR_W-1:0], halve_in, 1'b0))
                     << INC_SHIFT;
    assign core_inc = ACC_W'(ratio_quarters(msel[pcc_pkg::FACTOR_W-1:0], halve_in,
                                            msel[pcc_pkg::MSEL_B6])) << INC_SHIFT;

    // The setting last seen, so a new ratio restarts the lock interval.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cfg_prev <= 8'h00;
        end
        else
        begin
            cfg_prev <= {msel, halve_in};
        end
    end

    // Lock counter counts input clock edges while the loop runs; powering
    // the loop down or changing the ratio starts the interval again.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lock_cnt <= 9'h000;
        end
        else if (!loop_on || (cfg_prev != {msel, halve_in}))
        begin
            lock_cnt <= 9'h000;
        end
        else if (ref_rise && (lock_cnt != pcc_pkg::LOCK_CYCLES))
        begin
            lock_cnt <= lock_cnt + 9'h001;
        end
    end

    assign locked = (lock_cnt == pcc_pkg::LOCK_CYCLES);
    // Bypass stays in force until lock; from reset the count is zero, so
    // the core always starts from the input clock.
    assign use_loop = ~ctrl[pcc_pkg::BIT_BYPASS] & locked & loop_on;

    // Loop oscillator and core phase; both freeze at zero when the loop is
    // off or asleep, which also stops its input.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            vco_acc <= '0;
            core_acc <= '0;
        end
        else if (!loop_on)
        begin
            vco_acc <= '0;
            core_acc <= '0;
        end
        else
        begin
            vco_acc <= vco_acc + vco_inc;
            core_acc <= core_acc + core_inc;
        end
    end

    // Halved input clock for bypass operation.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            byp_half <= 1'b0;
        end
        else if (ref_rise)
        begin
            byp_half <= ~byp_half;
        end
    end

    assign bypass_src = ctrl[pcc_pkg::BIT_BYP_HALF] ? byp_half : ref_s;

    // Core source selection between bypass path and loop output.
    pcc_clk_switch u_core_sel (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .src_a_i(bypass_src),
        .src_b_i(core_acc[ACC_W-1]),
        .sel_b_i(use_loop),
        .halt_i(1'b0),
        .clk_o(core_raw)
    );

    // Core clock gate: parks high under either halt bit.
    pcc_clk_switch u_core_gate (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .src_a_i(core_raw),
        .src_b_i(core_raw),
        .sel_b_i(1'b0),
        .halt_i(ctrl[pcc_pkg::BIT_HALT_ALL] | ctrl[pcc_pkg::BIT_HALT_CORE]),
        .clk_o(core_clk_o)
    );

    // Peripheral half rate is taken from the ungated core source, so halting
    // only the core leaves the peripherals running.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            core_raw_d <= 1'b0;
            core_half <= 1'b0;
        end
        else
        begin
            core_raw_d <= core_raw;
            if (core_raw && !core_raw_d)
            begin
                core_half <= ~core_half;
            end
        end
    end

    // Peripheral clock: full or half core rate, parked high by halt all.
    pcc_clk_switch u_periph (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .src_a_i(core_raw),
        .src_b_i(core_half),
        .sel_b_i(ctrl[pcc_pkg::BIT_RATIO]),
        .halt_i(ctrl[pcc_pkg::BIT_HALT_ALL]),
        .clk_o(periph_clk_o)
    );

    // Clock pin, loop oscillator view and lock status, all registered.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            clock_out_pin_o <= 1'b0;
            pll_vco_clk_o <= 1'b0;
            lock_counter_reg_o <= 9'h000;
            pll_locked_o <= 1'b0;
        end
        else
        begin
            clock_out_pin_o <= ctrl[pcc_pkg::BIT_CKOUT] & periph_clk_o;
            pll_vco_clk_o <= loop_on & vco_acc[ACC_W-1];
            lock_counter_reg_o <= lock_cnt;
            pll_locked_o <= locked;
        end
    end

endmodule
`default_nettype wire

// file: tb/pcc_pll_clock_controller_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the top ports, with a mirror of the control register.
module pcc_ctrl_checker #(
    parameter int ADDR_W = 16 // Address width, as on the design.
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [6:0] multiplier_strap_i,
    input wire logic bypass_strap_i,
    input wire logic input_halving_strap_i,
    input wire logic [ADDR_W-1:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    input wire logic [15:0] io_rdata_o,
    input wire logic [8:0] lock_counter_reg_o,
    input wire logic core_clk_o,
    input wire logic periph_clk_o,
    input wire logic clock_out_pin_o,
    input wire logic pll_vco_clk_o
);
    logic [15:0] shadow; // Mirror of the control register.
    logic [1:0] settle; // Edges since reset release.
    logic taken; // High once the straps sit in the mirror.
    logic [9:0] halt_cnt; // Cycles spent with all clocks halted.
    wire logic hit = io_addr_i == pcc_pkg::CTRL_ADDR; // Control register addressed.

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // The mirror takes the straps on the fourth edge, as the design does.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            shadow <= pcc_pkg::CTRL_RST;
            settle <= 2'h0;
            taken <= 1'b0;
        end
        else if (!taken)
        begin
            settle <= settle + 2'h1;
            if (settle == pcc_pkg::STRAP_SETTLE)
            begin
                shadow <= {multiplier_strap_i, bypass_strap_i, 7'h00, input_halving_strap_i};
                taken <= 1'b1;
            end
        end
        else if (io_wr_i && hit)
        begin
            shadow <= io_wdata_i;
        end
    end

    // Halt dwell counter; the gate may wait for a high phase before it parks.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            halt_cnt <= 10'h000;
        end
        else
        begin
            halt_cnt <= shadow[2] ? halt_cnt + {9'h000, ~&halt_cnt} : 10'h000;
        end
    end

    AST_READ_DATA: assert property (io_rdata_o == ($past(io_rd_i && hit) ? $past(shadow) : 16'h0000))
        else $error("read data differs from the control register");
    AST_LOCK_CEILING: assert property (lock_counter_reg_o <= pcc_pkg::LOCK_CYCLES)
        else $error("lock count passed its ceiling");
    AST_LOCK_STEP: assert property ($changed(lock_counter_reg_o) |-> lock_counter_reg_o == 9'h000 || lock_counter_reg_o == $past(lock_counter_reg_o) + 9'h001)
        else $error("lock count jumped");
    AST_SLEEP_CLEARS: assert property ($rose(shadow[5]) |-> ##[1:4] lock_counter_reg_o == 9'h000)
        else $error("lock count kept after sleep");
    AST_SHUTOFF_STOPS: assert property (shadow[1] [*4] |-> !pll_vco_clk_o)
        else $error("loop clock runs while shut off");
    AST_CKOUT_LOW: assert property (!shadow[6] && !$past(shadow[6]) |-> !clock_out_pin_o)
        else $error("clock pin not low while gated");
    AST_CKOUT_FOLLOWS: assert property (shadow[6] && $past(shadow[6]) |-> clock_out_pin_o == $past(periph_clk_o))
        else $error("clock pin does not follow the peripheral clock");
    AST_HALT_ALL: assert property (halt_cnt >= 10'h12C |-> core_clk_o && periph_clk_o)
        else $error("clocks not parked high while halted");

    COV_READ: cover property (io_rd_i && hit);
    COV_HALT: cover property (halt_cnt == 10'h12C);
    COV_LOCK: cover property (lock_counter_reg_o == pcc_pkg::LOCK_CYCLES && !shadow[8]);
endmodule

`default_nettype wire

// file: tb/pcc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the board: an oscillator and the strap resistors.
module pcc_osc_model #(
    parameter int HALF_NS = 800, // Half period of the input clock.
    parameter logic [6:0] MSEL = 7'h06, // Multiplier strap resistors; bit 5 stays clear.
    parameter logic BYPASS = 1'b1, // Bypass strap resistor.
    parameter logic HALVE = 1'b0 // Halving strap resistor.
) (
    output var logic input_clk_o,
    output logic [6:0] multiplier_strap_o,
    output logic bypass_strap_o,
    output logic input_halving_strap_o
);
    // Straps are resistors, so they hold steady from time zero through reset.
    assign multiplier_strap_o = MSEL;
    assign bypass_strap_o = BYPASS;
    // The input is far below the limit, so halving stays low and bit 5 needs none.
    assign input_halving_strap_o = HALVE;
    // The oscillator free-runs through reset so recovery is quick; odd start phase.
    initial
    begin
        input_clk_o = 1'b0;
        #337;
        forever #(HALF_NS) input_clk_o = ~input_clk_o;
    end
endmodule

`default_nettype wire

// file: tb/tb_pll_clock_controller.sv
`timescale 1ns/1ps
`default_nettype none

// Register traffic plus edge counts of the derived clocks over fixed windows.
module tb_pll_clock_controller;
    localparam int WIN = 512; // Window in system cycles; the input period is 16.
    localparam int LIMIT = 60000; // Run ceiling in system cycles.
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic input_clk_i;
    logic [6:0] multiplier_strap_i;
    logic bypass_strap_i;
    logic input_halving_strap_i;
    logic [15:0] io_addr_i = 16'h0000;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [15:0] io_wdata_i = 16'h0000;
    logic [15:0] io_rdata_o;
    logic [8:0] lock_counter_reg_o;
    logic pll_locked_o;
    logic core_clk_o;
    logic periph_clk_o;
    logic clock_out_pin_o;
    logic pll_vco_clk_o;
    logic [15:0] exp_q[$]; // Expected read words, oldest first.
    logic rd_last = 1'b0; // A read was taken at the previous edge.
    logic [31:0] seed = 32'h4AD898C9; // Xorshift state.
    int cnt[4]; // Rising edges of core, peripheral, pin and loop clocks.
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    pcc_osc_model #(.HALF_NS(800)) osc_u (
        .input_clk_o(input_clk_i),
        .multiplier_strap_o(multiplier_strap_i),
        .bypass_strap_o(bypass_strap_i),
        .input_halving_strap_o(input_halving_strap_i)
    );

    // A shorter input period keeps the 500-edge lock wait affordable.
    pcc_pll_clock_controller #(.REF_LOG2(4)) dut_u (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .input_clk_i(input_clk_i),
        .multiplier_strap_i(multiplier_strap_i),
        .bypass_strap_i(bypass_strap_i),
        .input_halving_strap_i(input_halving_strap_i),
        .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o),
        .lock_counter_reg_o(lock_counter_reg_o),
        .pll_locked_o(pll_locked_o),
        .core_clk_o(core_clk_o),
        .periph_clk_o(periph_clk_o),
        .clock_out_pin_o(clock_out_pin_o),
        .pll_vco_clk_o(pll_vco_clk_o)
    );

    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Each window end may lose one edge, so one either way is allowed.
    function automatic logic [15:0] near(input int got, input int exp);
        return (got >= exp - 1 && got <= exp + 1) ? 16'(exp) : 16'(got);
    endfunction

    // One-cycle strobes, launched after a falling edge.
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(negedge sys_clk_i);
        io_addr_i = addr;
        io_wdata_i = data;
        io_wr_i = 1'b1;
        @(negedge sys_clk_i);
        io_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
        exp_q.push_back(exp);
        @(negedge sys_clk_i);
        io_addr_i = addr;
        io_rd_i = 1'b1;
        @(negedge sys_clk_i);
        io_rd_i = 1'b0;
    endtask

    // Read data is due one edge after the strobe.
    always @(posedge sys_clk_i)
    begin
        if (rd_last)
        begin
            check(io_rdata_o, exp_q.pop_front());
        end
        rd_last = io_rd_i;
        cyc++;
        if (cyc == LIMIT)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic measure();
        logic [3:0] prev;
        logic [3:0] now;
        prev = 4'hF;
        cnt = '{0, 0, 0, 0};
        repeat (WIN)
        begin
            @(negedge sys_clk_i);
            now = {pll_vco_clk_o, clock_out_pin_o, periph_clk_o, core_clk_o};
            for (int i = 0; i < 4; i++)
            begin
                cnt[i] += int'(now[i] && !prev[i]);
            end
            prev = now;
        end
    endtask

    // Writes a control word, reads it back, may wait for lock, then counts edges.
    // An expectation of -1 leaves that clock unjudged.
    task automatic run_case(input logic [15:0] ctrl, input bit lock, input int ec, input int ep,
        input int ek, input int ev);
        int exp[4];
        int n;
        exp = '{ec, ep, ek, ev};
        n = 0;
        wr(16'h0200, ctrl);
        rd(16'h0200, ctrl);
        while (lock && pll_locked_o !== 1'b1 && n < 9600)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        if (lock)
        begin
            check({7'h00, lock_counter_reg_o}, 16'h01F4);
            check({15'h0000, pll_locked_o}, 16'h0001);
        end
        repeat (200) @(negedge sys_clk_i);
        measure();
        for (int i = 0; i < 4; i++)
        begin
            if (exp[i] >= 0)
            begin
                check(near(cnt[i], exp[i]), 16'(exp[i]));
            end
        end
        $display("case %h done", ctrl);
    endtask

    initial
    begin
        logic [15:0] d;
        logic [15:0] a;
        repeat (8) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        // Straps give multiplier 6 with bypass; the core runs from the input clock.
        rd(16'h0200, 16'h0D00);
        measure();
        check(near(cnt[0], 32), 16'h0020);
        $display("strap test done");
        // Random words read back whole; a stray address neither writes nor reads.
        repeat (3)
        begin
            seed = next_rand(seed);
            d = seed[15:0];
            a = 16'h0200 ^ {seed[23:16] | 8'h01, 8'h00};
            wr(16'h0200, d);
            wr(a, ~d);
            rd(16'h0200, d);
            rd(a, 16'h0000);
        end
        $display("register test done");
        run_case(16'h0D40, 0, 32, 32, 32, -1);
        run_case(16'h0DC0, 0, 16, 16, 16, -1);
        run_case(16'h0DD0, 0, 16, 8, 8, -1);
        run_case(16'h0D10, 0, 32, 16, 0, -1);
        run_case(16'h0D48, 0, 0, -1, -1, -1);
        run_case(16'h0D44, 0, 0, 0, 0, -1);
        run_case(16'h0D60, 0, 32, 32, 32, 0);
        wr(16'h0200, 16'h0542);
        wr(16'h0200, 16'h0540);
        run_case(16'h0440, 0, 32, 32, 32, -1);
        run_case(16'h0440, 1, 64, 64, 64, 64);
        wr(16'h0200, 16'h0943);
        wr(16'h0200, 16'h0941);
        run_case(16'h0841, 1, 64, 64, 64, 64);
        wr(16'h0200, 16'hC543);
        wr(16'h0200, 16'hC541);
        run_case(16'hC441, 1, 32, 32, 32, 64);
        print_verdict();
    end
endmodule

bind pcc_pll_clock_controller pcc_ctrl_checker #(.ADDR_W(ADDR_W)) chk_u (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .multiplier_strap_i(multiplier_strap_i),
    .bypass_strap_i(bypass_strap_i),
    .input_halving_strap_i(input_halving_strap_i),
    .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .lock_counter_reg_o(lock_counter_reg_o),
    .core_clk_o(core_clk_o),
    .periph_clk_o(periph_clk_o),
    .clock_out_pin_o(clock_out_pin_o),
    .pll_vco_clk_o(pll_vco_clk_o)
);

`default_nettype wire
